// ==== core/current_ref_pkg.sv ====
/*
 Constants shared by the current reference control block: register addresses,
 field positions, reset values and step weights.
 Assumes an 8-bit special-function-register bus clocked by the system clock.
*/
// What this block does
// - Control bit 7 picks direction: zero sources current, one sinks it.
// - Control bit 6 picks range: zero gives 1 uA steps, one gives 8 uA.
// - Bits 5:0 are the step count; current is sign times step times count.
// - A nonzero count enables the reference; writing 0x00 disables it.
// - After reset the control register reads zero: disabled, sourcing, low range.
// - With trim enabled, the chosen compare output gates an extra two-LSB source.
// - Count LSBs 00b with trim fully on equals count LSBs set to 10b.
package current_ref_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hD6;
   localparam logic [7:0] CFG_ADDR = 8'hB9;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_MASK = 8'h87;
   localparam int SINK_BIT = 7;
   localparam int RANGE_BIT = 6;
   localparam int COUNT_MSB = 5;
   localparam int TRIM_EN_BIT = 7;
   localparam int TRIM_SEL_MSB = 2;
   localparam int NUM_CH = 6;
   localparam logic [2:0] LAST_CH = 3'h5;
   localparam logic [6:0] TRIM_WEIGHT = 7'h02;
   localparam logic [3:0] STEP_LOW_UA = 4'h1;
   localparam logic [3:0] STEP_HIGH_UA = 4'h8;
endpackage

// ==== core/current_reference.sv ====
/*
 Control logic of the programmable current reference: the control and trim
 configuration registers on the special-function-register bus, and registered
 settings for the analog source/sink stage.
 Assumes single-cycle bus strobes on ref_clk and a synchronous active-low reset.
*/
module current_reference
   import current_ref_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Register bus
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWdata,
   input wire logic sfrRd,
   output logic [7:0] sfrRdata,
   // Counter-array compare outputs
   input wire logic [NUM_CH-1:0] compareOutput,
   // Analog stage controls
   output logic sinkMode,
   output logic highRange,
   output logic [5:0] stepCount,
   output logic refEnable,
   output logic trimOn,
   output logic [9:0] currentUa
);
   logic [7:0] ctrl_r;
   logic [7:0] cfg_r;
   logic [7:0] rdata_r;
   logic sink_r;
   logic range_r;
   logic [5:0] count_r;
   logic enable_r;
   logic [9:0] current_r;
   trim_if tr ();

   function automatic logic [3:0] stepSize(input logic high);
      stepSize = high ? STEP_HIGH_UA : STEP_LOW_UA;
   endfunction

   // Register writes
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         ctrl_r <= CTRL_RESET;
      else if (sfrWr && sfrAddr == CTRL_ADDR)
         ctrl_r <= sfrWdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         cfg_r <= CFG_RESET;
      else if (sfrWr && sfrAddr == CFG_ADDR)
         cfg_r <= sfrWdata & CFG_MASK;
   end

   // Register reads; unmapped addresses read zero
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         rdata_r <= 8'h00;
      else if (sfrRd)
      begin
         case (sfrAddr)
            CTRL_ADDR: rdata_r <= ctrl_r;
            CFG_ADDR: rdata_r <= cfg_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   // Analog settings, registered so they change together
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         sink_r <= 1'b0;
         range_r <= 1'b0;
         count_r <= 6'h00;
         enable_r <= 1'b0;
      end
      else
      begin
         sink_r <= ctrl_r[SINK_BIT];
         range_r <= ctrl_r[RANGE_BIT];
         count_r <= ctrl_r[COUNT_MSB:0];
         enable_r <= ctrl_r[COUNT_MSB:0] != 6'h00;
      end
   end

   // Trim gate is computed from the same register state as enable_r, keeping them aligned
   assign tr.enable = cfg_r[TRIM_EN_BIT];
   assign tr.refOn = ctrl_r[COUNT_MSB:0] != 6'h00;
   assign tr.sel = cfg_r[TRIM_SEL_MSB:0];

   trim_pwm_select u_trim (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .compareOutput(compareOutput),
      .tr(tr)
   );

   // Nominal magnitude in microamps; a fully-on trim adds two LSBs
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         current_r <= 10'h000;
      else
         current_r <= 10'({1'b0, count_r} + (tr.gate ? TRIM_WEIGHT : 7'h00)) * 10'(stepSize(range_r));
   end

   assign sfrRdata = rdata_r;
   assign sinkMode = sink_r;
   assign highRange = range_r;
   assign stepCount = count_r;
   assign refEnable = enable_r;
   assign trimOn = tr.gate;
   assign currentUa = current_r;

   property p_sink;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrWr && sfrAddr == CTRL_ADDR) ##1 !(sfrWr && sfrAddr == CTRL_ADDR) |-> ##1 sink_r == $past(sfrWdata[7], 2);
   endproperty
   a_sink: assert property (p_sink) else $error("direction not taken from bit 7");

   property p_range;
      @(posedge ref_clk) disable iff (!rstn)
         (!tr.gate && !$past(tr.gate)) |=> current_r == 10'(count_r) * 10'(stepSize(range_r)) || $changed(count_r)
            || $changed(range_r);
   endproperty
   a_range: assert property (p_range) else $error("current not step size times count");

   property p_count;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrWr && sfrAddr == CTRL_ADDR) ##1 !(sfrWr && sfrAddr == CTRL_ADDR) |-> ##1 count_r == $past(sfrWdata[5:0], 2);
   endproperty
   a_count: assert property (p_count) else $error("step count not taken from bits 5:0");

   property p_disable;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrWr && sfrAddr == CTRL_ADDR && sfrWdata == 8'h00) ##1 !(sfrWr && sfrAddr == CTRL_ADDR) |-> ##1 !enable_r;
   endproperty
   a_disable: assert property (p_disable) else $error("reference on after zero write");

   property p_enable;
      @(posedge ref_clk) disable iff (!rstn)
         enable_r == (count_r != 6'h00);
   endproperty
   a_enable: assert property (p_enable) else $error("enable disagrees with count");

   property p_reset;
      @(posedge ref_clk)
         (rstn && !$past(rstn)) |-> ctrl_r == CTRL_RESET && !sink_r && !range_r && !enable_r;
   endproperty
   a_reset: assert property (p_reset) else $error("control not zero after reset");

   property p_trim_weight;
      @(posedge ref_clk) disable iff (!rstn)
         (tr.gate && count_r[1:0] == 2'b00) |=> current_r == 10'($past(count_r) | 6'h02) * 10'(stepSize($past(range_r)));
   endproperty
   a_trim_weight: assert property (p_trim_weight) else $error("full trim not equal to LSBs 10b");

   property p_trim_gated;
      @(posedge ref_clk) disable iff (!rstn)
         !cfg_r[TRIM_EN_BIT] ##1 !cfg_r[TRIM_EN_BIT] |-> !tr.gate;
   endproperty
   a_trim_gated: assert property (p_trim_gated) else $error("trim on with enable clear");

   // Bounds follow from the 6-bit count: at most 63 steps of 1 uA or 8 uA
   property p_low_max;
      @(posedge ref_clk) disable iff (!rstn)
         (!range_r && !tr.gate) |=> current_r <= 10'h03F;
   endproperty
   a_low_max: assert property (p_low_max) else $error("low range current above its ceiling");

   property p_high_max;
      @(posedge ref_clk) disable iff (!rstn)
         (range_r && !tr.gate) |=> current_r <= 10'h1F8;
   endproperty
   a_high_max: assert property (p_high_max) else $error("high range current above its ceiling");

   // The trim source adds whole steps, so high range stays a multiple of 8 uA
   property p_high_step;
      @(posedge ref_clk) disable iff (!rstn)
         range_r |=> current_r[2:0] == 3'h0;
   endproperty
   a_high_step: assert property (p_high_step) else $error("high range current not whole 8 uA steps");

   property p_range_bit;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrWr && sfrAddr == CTRL_ADDR) ##1 !(sfrWr && sfrAddr == CTRL_ADDR) |-> ##1 range_r == $past(sfrWdata[6], 2);
   endproperty
   a_range_bit: assert property (p_range_bit) else $error("range not taken from bit 6");

   property p_off_zero;
      @(posedge ref_clk) disable iff (!rstn)
         (!enable_r && !tr.gate) |=> current_r == 10'h000;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("current flows while disabled");

   property p_trim_needs_ref;
      @(posedge ref_clk) disable iff (!rstn)
         tr.gate |-> enable_r;
   endproperty
   a_trim_needs_ref: assert property (p_trim_needs_ref) else $error("trim on while reference disabled");

   // Control changes only through a bus write to its own address
   property p_ctrl_hold;
      @(posedge ref_clk) disable iff (!rstn)
         !(sfrWr && sfrAddr == CTRL_ADDR) |=> $stable(ctrl_r);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without a write");

   property p_read_ctrl;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrRd && sfrAddr == CTRL_ADDR) |=> rdata_r == $past(ctrl_r);
   endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control read back wrong");

   property p_read_cfg;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrRd && sfrAddr == CFG_ADDR) |=> rdata_r == $past(cfg_r);
   endproperty
   a_read_cfg: assert property (p_read_cfg) else $error("trim config read back wrong");

   property p_cfg_mask;
      @(posedge ref_clk) disable iff (!rstn)
         (sfrWr && sfrAddr == CFG_ADDR) |=> (cfg_r & ~CFG_MASK) == 8'h00;
   endproperty
   a_cfg_mask: assert property (p_cfg_mask) else $error("unused trim config bits stored");
endmodule

// ==== core/trim_if.sv ====
/*
 Carries the trim settings from the control registers to the trim gate and
 the gate state back.
 Assumes both ends run on the same system clock.
*/
interface trim_if;
   logic enable;
   logic refOn;
   logic [2:0] sel;
   logic gate;
   modport ctrl (output enable, output refOn, output sel, input gate);
   modport gater (input enable, input refOn, input sel, output gate);
endinterface

// ==== core/trim_pwm_select.sv ====
/*
 Picks one counter-array compare output and gates the two-LSB trim source.
 Assumes the compare outputs come from logic on the same system clock.
*/
module trim_pwm_select
   import current_ref_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Counter-array compare outputs
   input wire logic [NUM_CH-1:0] compareOutput,
   // Settings and gate
   trim_if.gater tr
);
   logic gate_r;

   // Channel numbers past the last one select nothing rather than an unknown bit
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         gate_r <= 1'b0;
      else if (tr.enable && tr.refOn && tr.sel <= LAST_CH)
         gate_r <= compareOutput[tr.sel];
      else
         gate_r <= 1'b0;
   end

   assign tr.gate = gate_r;

   property p_trim_follow;
      @(posedge ref_clk) disable iff (!rstn)
         (tr.enable && tr.refOn && tr.sel <= LAST_CH) |=> (gate_r == $past(compareOutput[tr.sel]));
   endproperty
   a_trim_follow: assert property (p_trim_follow) else $error("trim gate does not follow compare output");

   property p_trim_off;
      @(posedge ref_clk) disable iff (!rstn)
         (!tr.enable || !tr.refOn) |=> !gate_r;
   endproperty
   a_trim_off: assert property (p_trim_off) else $error("trim gate on while disabled");
endmodule

// ==== testbench/analog_stage_model.sv ====
/*
 Behavioural analog source/sink stage: turns the registered settings into a
 signed current in uA, where a negative value means the stage sinks.
 Assumes the settings come straight from the control block on the system clock.
*/
module analog_stage_model
(
   // Settings
   input wire logic sinkMode,
   input wire logic highRange,
   input wire logic [5:0] stepCount,
   input wire logic refEnable,
   input wire logic trimOn,
   // Resulting current
   output int currentOut
);
   timeunit 1ns;
   timeprecision 100ps;
   int mag;
   always_comb
   begin
      // The trim source adds two steps while gated on
      mag = (highRange ? 8 : 1) * (int'(stepCount) + (trimOn ? 2 : 0));
      // A disabled stage draws nothing
      if (!refEnable)
         mag = 0;
      currentOut = sinkMode ? -mag : mag;
   end
endmodule

// ==== testbench/current_reference_tb.sv ====
/*
 Self-checking bench for current_reference: register bus tasks and compare outputs.
 Assumes the design package and the analog stage model are compiled first.
*/
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("wrong value %0t: got %0h", $time, a); end end
module current_reference_tb
   import current_ref_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] sfrAddr = 8'h00;
   logic sfrWr = 1'b0;
   logic [7:0] sfrWdata = 8'h00;
   logic sfrRd = 1'b0;
   logic [7:0] sfrRdata;
   logic [5:0] compareOutput = 6'h00;
   logic sinkMode, highRange, refEnable, trimOn;
   logic [5:0] stepCount;
   logic [9:0] currentUa;
   int currentOut;
   int fails = 0;
   int check_count = 0;
   always #2 ref_clk = ~ref_clk;
   current_reference i_dut (.ref_clk(ref_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
      .sfrWdata(sfrWdata), .sfrRd(sfrRd), .sfrRdata(sfrRdata), .compareOutput(compareOutput),
      .sinkMode(sinkMode), .highRange(highRange), .stepCount(stepCount), .refEnable(refEnable),
      .trimOn(trimOn), .currentUa(currentUa));
   analog_stage_model i_stage (.sinkMode(sinkMode), .highRange(highRange), .stepCount(stepCount),
      .refEnable(refEnable), .trimOn(trimOn), .currentOut(currentOut));
   // Inputs always change 1 ns after a rising edge
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Three idle cycles let the setting reach currentUa
   task automatic wr(logic [7:0] a, logic [7:0] d);
      sfrAddr = a;
      sfrWdata = d;
      sfrWr = 1'b1;
      tick(1);
      sfrWr = 1'b0;
      tick(3);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      sfrAddr = a;
      sfrRd = 1'b1;
      tick(1);
      sfrRd = 1'b0;
      tick(1);
      `CHK(sfrRdata, exp)
   endtask
   task automatic test_reset();
      rd(CTRL_ADDR, CTRL_RESET);
      rd(CFG_ADDR, CFG_RESET);
      `CHK({sinkMode, highRange, refEnable, trimOn, currentUa}, 14'h0000)
      $display("test_reset done");
   endtask
   task automatic test_fields();
      wr(CTRL_ADDR, 8'hBF);
      rd(CTRL_ADDR, 8'hBF);
      `CHK(currentOut, -63)
      wr(CTRL_ADDR, 8'h45);
      `CHK(currentUa, 10'h028)
      `CHK({sinkMode, refEnable}, 2'h1)
      `CHK({highRange, stepCount}, 7'h45)
      `CHK(currentOut, 40)
      wr(CTRL_ADDR, 8'h00);
      `CHK({refEnable, currentUa}, 11'h000)
      rd(8'hD7, 8'h00);
      $display("test_fields done");
   endtask
   task automatic test_trim();
      // Every channel must be usable as the fine trim source
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
         wr(CFG_ADDR, 8'h80 | 8'(ch));
         wr(CTRL_ADDR, 8'h04);
         compareOutput = 6'h01 << ch;
         tick(3);
         `CHK(currentUa, 10'h006)
         compareOutput = ~(6'h01 << ch);
         tick(3);
         `CHK({trimOn, currentUa}, 11'h004)
      end
      compareOutput = 6'h3F;
      wr(CTRL_ADDR, 8'h00);
      `CHK({trimOn, currentUa}, 11'h000)
      // Channel 5 is high, so only the clear enable keeps the trim off
      wr(CFG_ADDR, 8'h05);
      wr(CTRL_ADDR, 8'h04);
      `CHK({trimOn, currentUa}, 11'h004)
      // Channel 7 does not exist and selects nothing; bits 6:3 are not stored
      wr(CFG_ADDR, 8'hFF);
      rd(CFG_ADDR, CFG_MASK);
      `CHK({trimOn, currentUa}, 11'h004)
      $display("test_trim done");
   endtask
   // A reset in mid-run must clear every setting, trim included
   task automatic test_mid_reset();
      wr(CFG_ADDR, 8'h85);
      wr(CTRL_ADDR, 8'hC4);
      `CHK({sinkMode, highRange, refEnable, trimOn, currentUa}, 14'h3C30)
      rstn = 1'b0;
      tick(2);
      rstn = 1'b1;
      `CHK({sinkMode, highRange, refEnable, trimOn, currentUa}, 14'h0000)
      rd(CTRL_ADDR, CTRL_RESET);
      rd(CFG_ADDR, CFG_RESET);
      `CHK({trimOn, currentUa}, 11'h000)
      $display("test_mid_reset done");
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      tick(8);
      rstn = 1'b1;
      tick(1);
      test_reset();
      test_fields();
      test_trim();
      test_mid_reset();
      conclude();
   end
   initial
   begin
      #20000;
      fails++;
      conclude();
   end
endmodule
